// *** include/encpos_pkg.sv ***
// shared constants and types of the encoder position front end
// assumes a 25 MHz module clock; bit and pause counts derive from it
package encpos_pkg;

    // module clock
    localparam int unsigned CLK_HZ      = 25_000_000;

    // serial bit rates, selected by rate_sel 0..3
    localparam int unsigned RATE0_KHZ   = 125;
    localparam int unsigned RATE1_KHZ   = 250;
    localparam int unsigned RATE2_KHZ   = 500;
    localparam int unsigned RATE3_KHZ   = 1000;

    // clock cycles per serial bit period
    localparam int unsigned BIT0_CYC    = CLK_HZ / (RATE0_KHZ * 1000);
    localparam int unsigned BIT1_CYC    = CLK_HZ / (RATE1_KHZ * 1000);
    localparam int unsigned BIT2_CYC    = CLK_HZ / (RATE2_KHZ * 1000);
    localparam int unsigned BIT3_CYC    = CLK_HZ / (RATE3_KHZ * 1000);

    // monoflop pause after each frame, least time so rounded up
    localparam int unsigned MONO_US     = 64;
    localparam int unsigned MONO_CYC    = (MONO_US * (CLK_HZ / 1000) + 999) / 1000;

    // frame layout
    localparam int unsigned LEN_SHORT   = 13;
    localparam int unsigned LEN_LONG    = 25;
    localparam int unsigned FRAME_W     = 25;
    localparam int unsigned CNT_W       = 12;
    localparam int unsigned IDX_W       = 5;

    // quadrature settle count after reset: three sync stages plus the filter,
    // so a pin that idles high never looks like an edge
    localparam int unsigned PRIME_CYC   = 4;

    // reset values
    localparam logic [31:0] POS_RST     = 32'h0000_0000;

    typedef enum logic [1:0] {
        SSI_OFF,
        SSI_FRAME,
        SSI_MONO
    } encpos_ssi_st_t;

endpackage : encpos_pkg

// *** rtl/encpos_quad.sv ***
// quadrature track decoder: synchronises A, B and zero marker, emits count steps
// assumes tracks are asynchronous pins; edge spacing at least a few clocks
`timescale 1ns/1ps
module encpos_quad (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic track_a,
    input  wire logic track_b,
    input  wire logic track_n,
    output logic      step,
    output logic      step_up,
    output logic      zero_pulse,
    output logic      both_err
);

    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] filt_q;
    logic [2:0] filt_d;
    logic [2:0] prime_q;
    logic [2:0] prime_d;
    logic       step_q;
    logic       step_d;
    logic       up_q;
    logic       up_d;
    logic       zero_q;
    logic       zero_d;
    logic       err_q;
    logic       err_d;
    logic       chg_a;
    logic       chg_b;

    always_comb begin
        filt_d  = filt_q;
        prime_d = prime_q;
        step_d  = 1'b0;
        up_d    = up_q;
        zero_d  = 1'b0;
        err_d   = 1'b0;
        chg_a   = 1'b0;
        chg_b   = 1'b0;
        // a level counts once second and third stage agree
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
        if (prime_q != 3'(encpos_pkg::PRIME_CYC)) begin
            // no events until synchronisers hold real pin levels
            prime_d = prime_q + 3'd1;
        end else begin
            chg_a  = filt_d[0] ^ filt_q[0];
            chg_b  = filt_d[1] ^ filt_q[1];
            step_d = chg_a ^ chg_b;
            if (step_d) begin
                up_d = filt_d[0] ^ filt_q[1];
            end
            // both tracks in one cycle: count lost, flagged
            err_d  = chg_a & chg_b;
            zero_d = filt_d[2] & ~filt_q[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q    <= 3'h0;
            s2_q    <= 3'h0;
            s3_q    <= 3'h0;
            filt_q  <= 3'h0;
            prime_q <= 3'h0;
            step_q  <= 1'b0;
            up_q    <= 1'b0;
            zero_q  <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            s1_q    <= {track_n, track_b, track_a};
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            filt_q  <= filt_d;
            prime_q <= prime_d;
            step_q  <= step_d;
            up_q    <= up_d;
            zero_q  <= zero_d;
            err_q   <= err_d;
        end
    end

    assign step       = step_q;
    assign step_up    = up_q;
    assign zero_pulse = zero_q;
    assign both_err   = err_q;

endmodule : encpos_quad

// *** rtl/encpos_top.sv ***
// encoder position front end: incremental quadrature or absolute serial encoder
// assumes encoder pins are asynchronous and the user controls sit on clk
`timescale 1ns/1ps

// Function
// - two quarter-shifted tracks plus optional zero marker
// - count every edge, four counts per increment
// - follow 500 kHz differential, 50 kHz single-ended
// - device drives serial clock, encoder shifts bits
// - serial position word is Gray coded only
// - frames of 13 or 25 bits
// - absolute mode: one count per increment
// - 64 us monoflop pause after each frame
// - four bit rates 0.125 to 1 MHz
// - frame lasts length plus one bit periods
// - update between one and two frames plus pause
module encpos_top #(
    parameter int unsigned POS_W = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             abs_mode,
    input  wire logic             long_frame,
    input  wire logic [1:0]       rate_sel,
    input  wire logic             track_a,
    input  wire logic             track_b,
    input  wire logic             track_n,
    input  wire logic             ssi_data,
    output logic                  ssi_clk,
    output logic [POS_W-1:0]      position,
    output logic [POS_W-1:0]      zero_position,
    output logic                  pos_valid,
    output logic                  zero_seen,
    output logic                  count_dir,
    output logic                  quad_error,
    output logic                  frame_busy
);

    localparam int unsigned CW = encpos_pkg::CNT_W;
    localparam int unsigned IW = encpos_pkg::IDX_W;
    localparam int unsigned FW = encpos_pkg::FRAME_W;

    // bit period in clocks for a rate selection
    function automatic logic [CW-1:0] bit_cycles(input logic [1:0] sel);
        logic [CW-1:0] r;
        case (sel)
            2'd0:    r = CW'(encpos_pkg::BIT0_CYC);
            2'd1:    r = CW'(encpos_pkg::BIT1_CYC);
            2'd2:    r = CW'(encpos_pkg::BIT2_CYC);
            default: r = CW'(encpos_pkg::BIT3_CYC);
        endcase
        return r;
    endfunction : bit_cycles

    // reflected Gray to binary; zero upper bits leave a short word intact
    function automatic logic [FW-1:0] gray_to_bin(input logic [FW-1:0] g);
        logic [FW-1:0] b;
        b[FW-1] = g[FW-1];
        for (int i = FW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    // quadrature decoder
    logic quad_step;
    logic quad_up;
    logic quad_zero;
    logic quad_err;

    encpos_quad u_quad (
        .clk        (clk),
        .rst_n      (rst_n),
        .track_a    (track_a),
        .track_b    (track_b),
        .track_n    (track_n),
        .step       (quad_step),
        .step_up    (quad_up),
        .zero_pulse (quad_zero),
        .both_err   (quad_err)
    );

    // serial data pin synchroniser
    logic sd1_q;
    logic sd2_q;
    logic sd3_q;
    logic sdf_q;
    logic sdf_d;

    always_comb begin
        sdf_d = sdf_q;
        if (sd2_q == sd3_q) begin
            sdf_d = sd3_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sd1_q <= 1'b0;
            sd2_q <= 1'b0;
            sd3_q <= 1'b0;
            sdf_q <= 1'b0;
        end else begin
            sd1_q <= ssi_data;
            sd2_q <= sd1_q;
            sd3_q <= sd2_q;
            sdf_q <= sdf_d;
        end
    end

    // serial frame engine
    encpos_pkg::encpos_ssi_st_t st_q;
    encpos_pkg::encpos_ssi_st_t st_d;
    logic [CW-1:0] per_q;
    logic [CW-1:0] per_d;
    logic [CW-1:0] cyc_q;
    logic [CW-1:0] cyc_d;
    logic [IW-1:0] idx_q;
    logic [IW-1:0] idx_d;
    logic [IW-1:0] len_q;
    logic [IW-1:0] len_d;
    logic [FW-1:0] shr_q;
    logic [FW-1:0] shr_d;
    logic          sclk_q;
    logic          sclk_d;
    logic          done;

    always_comb begin
        st_d  = st_q;
        per_d = per_q;
        cyc_d = cyc_q;
        idx_d = idx_q;
        len_d = len_q;
        shr_d = shr_q;
        done  = 1'b0;
        case (st_q)
            encpos_pkg::SSI_OFF: begin
                if (abs_mode) begin
                    // rate and length are frozen for the whole frame
                    st_d  = encpos_pkg::SSI_FRAME;
                    per_d = '0;
                    idx_d = '0;
                    shr_d = '0;
                    cyc_d = bit_cycles(rate_sel);
                    len_d = long_frame ? IW'(encpos_pkg::LEN_LONG)
                                       : IW'(encpos_pkg::LEN_SHORT);
                end
            end
            encpos_pkg::SSI_FRAME: begin
                if (per_q == cyc_q - CW'(1)) begin
                    per_d = '0;
                    if (idx_q == len_q) begin
                        // trailing period done: frame is len plus one periods
                        done  = 1'b1;
                        st_d  = encpos_pkg::SSI_MONO;
                    end else begin
                        // sample late in the high phase, clear of sync latency
                        shr_d = {shr_q[FW-2:0], sdf_q};
                        idx_d = idx_q + IW'(1);
                    end
                end else begin
                    per_d = per_q + CW'(1);
                end
            end
            encpos_pkg::SSI_MONO: begin
                if (per_q == CW'(encpos_pkg::MONO_CYC - 1)) begin
                    // one extra idle cycle in OFF keeps the pause above the limit
                    st_d  = encpos_pkg::SSI_OFF;
                    per_d = '0;
                end else begin
                    per_d = per_q + CW'(1);
                end
            end
            default: begin
                st_d  = encpos_pkg::SSI_OFF;
                per_d = '0;
            end
        endcase
        // clock idles high; each bit period is low for cyc_d >> 1 clocks, then high for the rest (12 low, 13 high at 1 MHz)
        sclk_d = !((st_d == encpos_pkg::SSI_FRAME) && (per_d < (cyc_d >> 1)));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q   <= encpos_pkg::SSI_OFF;
            per_q  <= '0;
            cyc_q  <= CW'(encpos_pkg::BIT0_CYC);
            idx_q  <= '0;
            len_q  <= IW'(encpos_pkg::LEN_SHORT);
            shr_q  <= '0;
            sclk_q <= 1'b1;
        end else begin
            st_q   <= st_d;
            per_q  <= per_d;
            cyc_q  <= cyc_d;
            idx_q  <= idx_d;
            len_q  <= len_d;
            shr_q  <= shr_d;
            sclk_q <= sclk_d;
        end
    end

    // position and status
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] pos_d;
    logic [POS_W-1:0] zpos_q;
    logic [POS_W-1:0] zpos_d;
    logic             valid_q;
    logic             valid_d;
    logic             zseen_q;
    logic             zseen_d;
    logic             dir_q;
    logic             dir_d;
    logic             qerr_q;
    logic             qerr_d;
    logic [FW-1:0]    bin_word;

    always_comb begin
        pos_d    = pos_q;
        zpos_d   = zpos_q;
        dir_d    = dir_q;
        valid_d  = 1'b0;
        zseen_d  = 1'b0;
        qerr_d   = 1'b0;
        // only Gray input is accepted, so it is always decoded
        bin_word = gray_to_bin(shr_q);
        if (abs_mode) begin
            if (done) begin
                // one count per encoder increment, no multiplication
                pos_d   = POS_W'(bin_word);
                valid_d = 1'b1;
            end
        end else begin
            if (quad_step) begin
                // every edge of one track alone moves the count by one
                pos_d   = quad_up ? pos_q + POS_W'(1) : pos_q - POS_W'(1);
                dir_d   = quad_up;
                valid_d = 1'b1;
            end
            if (quad_zero) begin
                zpos_d  = pos_d;
                zseen_d = 1'b1;
            end
            qerr_d = quad_err;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_q   <= POS_W'(encpos_pkg::POS_RST);
            zpos_q  <= POS_W'(encpos_pkg::POS_RST);
            valid_q <= 1'b0;
            zseen_q <= 1'b0;
            dir_q   <= 1'b0;
            qerr_q  <= 1'b0;
        end else begin
            pos_q   <= pos_d;
            zpos_q  <= zpos_d;
            valid_q <= valid_d;
            zseen_q <= zseen_d;
            dir_q   <= dir_d;
            qerr_q  <= qerr_d;
        end
    end

    assign ssi_clk       = sclk_q;
    assign position      = pos_q;
    assign zero_position = zpos_q;
    assign pos_valid     = valid_q;
    assign zero_seen     = zseen_q;
    assign count_dir     = dir_q;
    assign quad_error    = qerr_q;
    assign frame_busy    = (st_q == encpos_pkg::SSI_FRAME);

endmodule : encpos_top

// *** tb/encpos_checker.sv ***
// concurrent checks on the encoder position front end ports
// bound into encpos_top; one clock domain, synchronous reset
`timescale 1ns/1ps
module encpos_checker #(
    parameter int unsigned POS_W = 32
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             ssi_clk,
    input wire logic [POS_W-1:0] position,
    input wire logic [POS_W-1:0] zero_position,
    input wire logic             pos_valid,
    input wire logic             zero_seen,
    input wire logic             count_dir,
    input wire logic             frame_busy
);
    logic [15:0] lo_q, lo_d, hi_q, hi_d;
    logic [4:0]  nf_q, nf_d;
    logic        ck_q;
    // high count saturates so the long pause never wraps
    always_comb begin
        lo_d = ssi_clk ? 16'h0000 : lo_q + 16'h0001;
        hi_d = !ssi_clk ? 16'h0000 : (hi_q == 16'hffff ? hi_q : hi_q + 16'h0001);
        nf_d = !frame_busy ? 5'h00 : nf_q + {4'h0, ck_q & ~ssi_clk};
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lo_q <= 16'h0000;
            hi_q <= 16'hffff;
            nf_q <= 5'h00;
            ck_q <= 1'b1;
        end else begin
            lo_q <= lo_d;
            hi_q <= hi_d;
            nf_q <= nf_d;
            ck_q <= ssi_clk;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_idle_high; !frame_busy |-> ssi_clk; endproperty
    a_idle_high: assert property (p_idle_high) else $error("serial clock low outside frame");
    property p_step;
        pos_valid && !$past(frame_busy) |->
            position == (count_dir ? $past(position) + 1'b1 : $past(position) - 1'b1);
    endproperty
    a_step: assert property (p_step) else $error("step not one count in its direction");
    property p_stable; !pos_valid |-> $stable(position); endproperty
    a_stable: assert property (p_stable) else $error("position moved without valid");
    property p_low; $rose(ssi_clk) |-> lo_q inside {16'h000c, 16'h0019, 16'h0032, 16'h0064}; endproperty
    a_low: assert property (p_low) else $error("serial low phase length wrong");
    property p_high;
        $fell(ssi_clk) |-> hi_q inside {16'h000d, 16'h0019, 16'h0032, 16'h0064}
            || hi_q >= encpos_pkg::MONO_CYC;
    endproperty
    a_high: assert property (p_high) else $error("serial high phase or pause wrong");
    property p_frame; $fell(frame_busy) |-> nf_q == 5'h0e || nf_q == 5'h1a; endproperty
    a_frame: assert property (p_frame) else $error("frame clock count wrong");
    property p_frame_valid; $fell(frame_busy) |-> pos_valid; endproperty
    a_frame_valid: assert property (p_frame_valid) else $error("no update at frame end");
    property p_pulse; pos_valid |=> !pos_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
    property p_zero; zero_seen |-> zero_position == position; endproperty
    a_zero: assert property (p_zero) else $error("zero capture differs from position");
endmodule : encpos_checker
bind encpos_top encpos_checker #(.POS_W(POS_W)) encpos_checker_i (.clk(clk), .rst_n(rst_n),
    .ssi_clk(ssi_clk), .position(position), .zero_position(zero_position),
    .pos_valid(pos_valid), .zero_seen(zero_seen), .count_dir(count_dir),
    .frame_busy(frame_busy));

// *** tb/encpos_enc_model.sv ***
// absolute serial encoder model: Gray word out msb first, one bit per rising clock
// assumes the serial clock idles high and a frame opens on a falling edge
`timescale 1ns/1ps
module encpos_enc_model (
    input  wire logic        ssi_clk,
    input  wire logic        long_frame,
    input  wire logic [24:0] word,
    output logic             ssi_data
);
    logic [24:0] sh;
    logic        busy = 1'b0;
    int          n, k;
    initial ssi_data = 1'b1;
    // ready again at once, well inside the pause
    always @(negedge ssi_clk) begin
        if (!busy) begin
            busy = 1'b1;
            k = 0;
            n = long_frame ? 25 : 13;
            sh = word ^ (word >> 1);
        end
    end
    always @(posedge ssi_clk) begin
        if (busy) begin
            if (k < n) ssi_data <= sh[n-1-k];
            else begin
                // inverted line: no stale bit left behind
                ssi_data <= ~ssi_data;
                busy = 1'b0;
            end
            k = k + 1;
        end
    end
endmodule : encpos_enc_model

// *** tb/encpos_top_tb.sv ***
// self-checking bench: quadrature walk, marker, lost count, serial frames at all rates
// assumes encpos_top with the serial encoder model on its far side
`timescale 1ns/1ps
module encpos_top_tb;
    logic        clk = 1'b0, rst_n = 1'b0, abs_mode = 1'b0, long_frame = 1'b0;
    logic [1:0]  rate_sel = 2'h0;
    logic        track_a = 1'b0, track_b = 1'b0, track_n = 1'b0, ssi_data, ssi_clk;
    logic [31:0] position, zero_position, exp_pos = 32'h0000_0000;
    logic        pos_valid, zero_seen, count_dir, quad_error, frame_busy;
    logic        saw_err = 1'b0, saw_zero = 1'b0, last_up = 1'b0;
    logic [24:0] word = 25'h000_0000;
    int          err_total = 0, checks_done = 0, cyc = 0, ph = 0, len, n;
    always #20 clk = ~clk;
    encpos_top encpos_top_i (.clk(clk), .rst_n(rst_n), .abs_mode(abs_mode),
        .long_frame(long_frame), .rate_sel(rate_sel), .track_a(track_a), .track_b(track_b),
        .track_n(track_n), .ssi_data(ssi_data), .ssi_clk(ssi_clk), .position(position),
        .zero_position(zero_position), .pos_valid(pos_valid), .zero_seen(zero_seen),
        .count_dir(count_dir), .quad_error(quad_error), .frame_busy(frame_busy));
    encpos_enc_model encpos_enc_model_i (.ssi_clk(ssi_clk), .long_frame(long_frame),
        .word(word), .ssi_data(ssi_data));
    task automatic complete_run();
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic tick(int k);
        repeat (k) begin
            @(posedge clk);
            #2;
            saw_err = saw_err | quad_error;
            saw_zero = saw_zero | zero_seen;
        end
    endtask : tick
    task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val
    function automatic logic [1:0] qseq(int p);
        case (p % 4)
            0: return 2'b00;
            1: return 2'b10;
            2: return 2'b11;
            default: return 2'b01;
        endcase
    endfunction : qseq
    function automatic int exp_len(logic [1:0] r, logic lf);
        int p;
        p = r == 0 ? encpos_pkg::BIT0_CYC : r == 1 ? encpos_pkg::BIT1_CYC :
            r == 2 ? encpos_pkg::BIT2_CYC : encpos_pkg::BIT3_CYC;
        return ((lf ? encpos_pkg::LEN_LONG : encpos_pkg::LEN_SHORT) + 1) * p;
    endfunction : exp_len
    // a leading b counts up
    task automatic qstep(logic up, int gap);
        ph = up ? ph + 1 : ph + 3;
        last_up = up;
        {track_a, track_b} = qseq(ph);
        exp_pos = up ? exp_pos + 32'h0000_0001 : exp_pos - 32'h0000_0001;
        tick(gap);
    endtask : qstep
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h8f5b));
        tick(2);
        rst_n = 1'b1;
        tick(8);
        for (int i = 0; i < 4; i++) qstep(1'b1, 3);
        tick(8);
        chk_val("position", 32'h0000_0004, position);
        chk_val("count_dir", 32'h0000_0001, {31'h0, count_dir});
        for (int i = 0; i < 4; i++) qstep(1'b0, 3);
        tick(8);
        chk_val("position", 32'h0000_0000, position);
        chk_val("count_dir", 32'h0000_0000, {31'h0, count_dir});
        // gaps of 3..12 clocks span the fastest track rate
        repeat (200) qstep(1'($urandom), 3 + $urandom % 10);
        tick(8);
        chk_val("position", exp_pos, position);
        chk_val("count_dir", {31'h0, last_up}, {31'h0, count_dir});
        track_n = 1'b1;
        tick(8);
        chk_val("zero_seen", 32'h0000_0001, {31'h0, saw_zero});
        chk_val("zero_position", exp_pos, zero_position);
        track_n = 1'b0;
        ph = ph + 2;
        {track_a, track_b} = qseq(ph);
        tick(10);
        chk_val("quad_error", 32'h0000_0001, {31'h0, saw_err});
        chk_val("position", exp_pos, position);
        // mid-run reset with every track high: no false edge may follow
        saw_err = 1'b0;
        saw_zero = 1'b0;
        ph = 2;
        {track_a, track_b} = qseq(ph);
        track_n = 1'b1;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(10);
        chk_val("position", 32'h0000_0000, position);
        chk_val("zero_seen", 32'h0000_0000, {31'h0, saw_zero});
        chk_val("quad_error", 32'h0000_0000, {31'h0, saw_err});
        for (int f = 0; f < 8; f++) begin
            rate_sel = f[1:0];
            long_frame = f[2];
            word = f[2] ? 25'($urandom) : 25'($urandom & 32'h0000_1fff);
            if (f == 7) word = 25'h1ff_ffff;
            abs_mode = 1'b1;
            n = 0;
            while (!frame_busy && n < 2000) begin
                tick(1);
                n++;
            end
            if (f > 0) chk_val("pause_ok", 32'h0000_0001,
                {31'h0, n >= encpos_pkg::MONO_CYC && n < encpos_pkg::MONO_CYC + 8});
            // mid-frame rate change and track motion must both be ignored
            rate_sel = 2'($urandom);
            track_a = ~track_a;
            len = 0;
            while (frame_busy && len < 6000) begin
                tick(1);
                len++;
            end
            chk_val("frame_cycles", 32'(exp_len(f[1:0], f[2])), 32'(len));
            chk_val("pos_valid", 32'h0000_0001, {31'h0, pos_valid});
            chk_val("position", {7'h00, word}, position);
        end
        abs_mode = 1'b0;
        tick(4);
        complete_run();
    end
endmodule : encpos_top_tb
